// ### inc/hw_watchdog_params.svh
// Timing and code constants for the hardware watchdog and reset control
`ifndef HW_WATCHDOG_PARAMS_SVH
`define HW_WATCHDOG_PARAMS_SVH

// ****************************************
// Clocks
// ****************************************
`define CLK_MHZ 250
`define XTAL_HZ 32768
`define XTAL_PERIOD_NS 30517
`define XTAL_HALF_PERIOD_NS 15258

// ****************************************
// Watchdog timing
// ****************************************
`define WD_TIMEOUT_MS 1500
`define WD_LIMIT_XTAL (`WD_TIMEOUT_MS * `XTAL_HZ / 1000)
`define LAUNCH_DELAY_XTAL 4100
`define RST_PULSE_CYCLES (`XTAL_HALF_PERIOD_NS * `CLK_MHZ / 1000)
`define OSC_SLOW_LIMIT_CYCLES (2 * `XTAL_PERIOD_NS * `CLK_MHZ / 1000)

// ****************************************
// Codes and reset values
// ****************************************
`define DEBUG_CMD_WD_RESTART 8'h14
`define ZERO16 16'h0000
`define ZERO13 13'h0000
`define ZERO12 12'h000

`endif

// ### inc/hw_watchdog_pkg.sv
// Types shared by the hardware watchdog and reset control
`default_nettype none

package hw_watchdog_pkg;

  // ****************************************
  // Reset sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_PULSE = 3'b001,
    ST_HOLD  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_FAULT = 3'b100
  } seq_state_e;

  // ****************************************
  // Pin inputs, grouped for synchronising
  // ****************************************
  typedef struct packed {
    logic ext_reset_n;
    logic emu_reset_n;
    logic pf_below_bias;
    logic wd_disable;
    logic wake;
    logic xtal;
  } pins_s;

endpackage : hw_watchdog_pkg

`default_nettype wire

// ### rtl/hw_watchdog_reset_control.sv
// Hardware watchdog, crystal monitor and reset sequencer for the MPU core
`default_nettype none
`include "hw_watchdog_params.svh"

module hw_watchdog_reset_control
  import hw_watchdog_pkg::*;
#(
  parameter int WD_LIMIT = `WD_LIMIT_XTAL,
  parameter int LAUNCH_DELAY = `LAUNCH_DELAY_XTAL,
  parameter int OSC_SLOW_LIMIT = `OSC_SLOW_LIMIT_CYCLES
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic vbat_srst_i,
  // Pins
  input wire logic crystal_clock_32k_i,
  input wire logic external_reset_pin_n_i,
  input wire logic emulator_reset_pin_n_i,
  input wire logic power_fault_sense_below_i,
  input wire logic power_fault_sense_wd_disable_i,
  input wire logic wake_i,
  // Firmware and debug port
  input wire logic watchdog_refresh_bit_wr_i,
  input wire logic watchdog_overflow_flag_clr_i,
  input wire logic debug_cmd_valid_i,
  input wire logic [7:0] debug_cmd_i,
  // Outputs
  output logic mpu_reset_o,
  output logic mpu_launch_o,
  output logic digital_halt_o,
  output logic config_ram_clear_o,
  output logic watchdog_overflow_flag_o
);

  localparam logic [15:0] WD_LAST = 16'(WD_LIMIT - 1);
  localparam logic [12:0] LAUNCH_LAST = 13'(LAUNCH_DELAY - 1);
  localparam logic [11:0] PULSE_LAST = 12'(`RST_PULSE_CYCLES - 1);
  localparam logic [15:0] GAP_LAST = 16'(OSC_SLOW_LIMIT - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pins_s pins_raw;
  pins_s sync1;
  pins_s sync2;
  logic xtal_d;

  assign pins_raw = '{ext_reset_n: external_reset_pin_n_i, emu_reset_n: emulator_reset_pin_n_i,
                      pf_below_bias: power_fault_sense_below_i, wd_disable: power_fault_sense_wd_disable_i,
                      wake: wake_i, xtal: crystal_clock_32k_i};

  // Sync reset drops to idle levels so no false source appears at release
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1 <= '{ext_reset_n: 1'b1, emu_reset_n: 1'b1, wake: 1'b1, default: 1'b0};
      sync2 <= '{ext_reset_n: 1'b1, emu_reset_n: 1'b1, wake: 1'b1, default: 1'b0};
      xtal_d <= 1'b0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      xtal_d <= sync2.xtal;
    end
  end

  logic xtal_tick;
  logic wd_off;
  logic pin_src;
  logic emu_src;
  assign xtal_tick = sync2.xtal & ~xtal_d;
  assign wd_off = sync2.wd_disable;
  // Tying the sense pin high also masks the power-fault comparator
  assign pin_src = ~sync2.ext_reset_n | (sync2.pf_below_bias & ~wd_off);
  assign emu_src = ~sync2.emu_reset_n;

  // ****************************************
  // Watchdog counter and crystal monitor
  // ****************************************
  seq_state_e state;
  seq_state_e next_state;
  logic [15:0] wd_cnt;
  logic [15:0] next_wd_cnt;
  logic [15:0] gap_cnt;
  logic [15:0] next_gap_cnt;
  logic watchdog_overflow_flag;
  logic osc_slow;
  logic wd_restart;

  assign wd_restart = watchdog_refresh_bit_wr_i | ~sync2.wake
                    | (debug_cmd_valid_i & (debug_cmd_i == `DEBUG_CMD_WD_RESTART));
  // A refresh on the last crystal edge still counts as in time
  assign watchdog_overflow_flag = (state == ST_RUN) & ~wd_off & ~wd_restart & xtal_tick & (wd_cnt == WD_LAST);
  assign osc_slow = ~wd_off & ~xtal_tick & (gap_cnt == GAP_LAST);

  always_comb begin
    next_wd_cnt = wd_cnt;
    if (wd_off || state != ST_RUN || wd_restart) begin
      next_wd_cnt = `ZERO16;
    end else if (xtal_tick) begin
      next_wd_cnt = wd_cnt + 16'h0001;
    end
    next_gap_cnt = gap_cnt;
    if (xtal_tick || wd_off) begin
      next_gap_cnt = `ZERO16;
    end else if (gap_cnt != GAP_LAST) begin
      next_gap_cnt = gap_cnt + 16'h0001; // Saturates while the crystal stays stopped
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wd_cnt <= `ZERO16;
      gap_cnt <= `ZERO16;
    end else begin
      wd_cnt <= next_wd_cnt;
      gap_cnt <= next_gap_cnt;
    end
  end

  // ****************************************
  // Reset sequencer
  // ****************************************
  logic [11:0] pulse_cnt;
  logic [11:0] next_pulse_cnt;
  logic [12:0] wait_cnt;
  logic [12:0] next_wait_cnt;
  logic next_mpu_reset;
  logic next_mpu_launch;
  logic next_halt;

  always_comb begin
    next_state = state;
    next_pulse_cnt = `ZERO12;
    next_wait_cnt = `ZERO13;
    next_mpu_launch = 1'b0;
    case (state)
      ST_RUN: begin
        if (pin_src || emu_src) begin
          next_state = ST_HOLD;
        end else if (osc_slow) begin
          next_state = ST_FAULT;
        end else if (watchdog_overflow_flag) begin
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        next_pulse_cnt = pulse_cnt + 12'h001;
        if (pin_src || emu_src) begin
          next_state = ST_HOLD;
        end else if (pulse_cnt == PULSE_LAST) begin
          next_state = ST_WAIT;
        end
      end
      ST_HOLD: begin
        if (!pin_src && !emu_src) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_wait_cnt = wait_cnt + (xtal_tick ? 13'h0001 : 13'h0000);
        if (pin_src || emu_src) begin
          next_state = ST_HOLD;
        end else if (osc_slow) begin
          next_state = ST_FAULT;
        end else if (xtal_tick && wait_cnt == LAUNCH_LAST) begin
          next_state = ST_RUN;
          next_mpu_launch = 1'b1;
        end
      end
      ST_FAULT: begin
        // Reset pulse waits for the crystal to run again or the watchdog to be disabled; a pin source goes to hold at once
        if (pin_src || emu_src) begin
          next_state = ST_HOLD;
        end else if (xtal_tick || wd_off) begin
          next_state = ST_PULSE;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
    next_mpu_reset = (next_state == ST_PULSE) || (next_state == ST_HOLD);
    next_halt = pin_src;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_HOLD;
      pulse_cnt <= `ZERO12;
      wait_cnt <= `ZERO13;
      mpu_reset_o <= 1'b1;
      mpu_launch_o <= 1'b0;
      digital_halt_o <= 1'b1;
      config_ram_clear_o <= 1'b1;
    end else begin
      state <= next_state;
      pulse_cnt <= next_pulse_cnt;
      wait_cnt <= next_wait_cnt;
      mpu_reset_o <= next_mpu_reset;
      mpu_launch_o <= next_mpu_launch;
      digital_halt_o <= next_halt;
      config_ram_clear_o <= next_halt;
    end
  end

  // ****************************************
  // Battery-backed overflow flag
  // ****************************************
  logic flag_set;
  logic next_flag;

  // Set wins over a clear in the same cycle so no overflow is lost
  assign flag_set = watchdog_overflow_flag | ((state == ST_RUN || state == ST_WAIT) & osc_slow & ~pin_src & ~emu_src);

  always_comb begin
    next_flag = watchdog_overflow_flag_o;
    if (srst_i) begin
      // Digital reset freezes the flag; its set and clear logic may be unpowered
      next_flag = watchdog_overflow_flag_o;
    end else if (flag_set) begin
      next_flag = 1'b1;
    end else if (watchdog_overflow_flag_clr_i || ~sync2.ext_reset_n) begin
      next_flag = 1'b0;
    end
  end

  // Of the two resets only the battery reset clears it; the digital reset leaves it alone
  always_ff @(posedge clk_i) begin
    if (vbat_srst_i) begin
      watchdog_overflow_flag_o <= 1'b0;
    end else begin
      watchdog_overflow_flag_o <= next_flag;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_ovf_sets_flag;
    @(posedge clk_i) disable iff (srst_i || vbat_srst_i) watchdog_overflow_flag |=> watchdog_overflow_flag_o;
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag) else $error("overflow did not set flag");

  property p_ovf_pulse;
    @(posedge clk_i) disable iff (srst_i) watchdog_overflow_flag && !pin_src && !emu_src |=> mpu_reset_o [*8];
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow reset pulse missing");

  property p_launch_delay;
    @(posedge clk_i) disable iff (srst_i) mpu_launch_o |-> $past(wait_cnt, 1) == LAUNCH_LAST && !mpu_reset_o;
  endproperty
  a_launch_delay: assert property (p_launch_delay) else $error("launch before delay elapsed");

  property p_flag_kept;
    @(posedge clk_i) disable iff (vbat_srst_i) srst_i |=> $stable(watchdog_overflow_flag_o);
  endproperty
  a_flag_kept: assert property (p_flag_kept) else $error("flag lost in digital reset");

  property p_pin_clears_flag;
    @(posedge clk_i) disable iff (srst_i || vbat_srst_i) !sync2.ext_reset_n && !flag_set |=> !watchdog_overflow_flag_o;
  endproperty
  a_pin_clears_flag: assert property (p_pin_clears_flag) else $error("reset pin did not clear flag");

  property p_disable_holds;
    @(posedge clk_i) disable iff (srst_i)
      wd_off |=> wd_cnt == `ZERO16 && (digital_halt_o == !$past(sync2.ext_reset_n));
  endproperty
  a_disable_holds: assert property (p_disable_holds) else $error("disabled watchdog still counting");

  property p_restart;
    @(posedge clk_i) disable iff (srst_i) wd_restart |=> wd_cnt == `ZERO16;
  endproperty
  a_restart: assert property (p_restart) else $error("refresh did not restart count");

  property p_halt;
    @(posedge clk_i) disable iff (srst_i) pin_src |=> digital_halt_o && config_ram_clear_o && mpu_reset_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not asserted");

  property p_emu_reset;
    @(posedge clk_i) disable iff (srst_i) emu_src |=> mpu_reset_o;
  endproperty
  a_emu_reset: assert property (p_emu_reset) else $error("emulator reset not applied");

  property p_osc_fault;
    @(posedge clk_i) disable iff (srst_i) state == ST_RUN && osc_slow && !pin_src && !emu_src
      |=> state == ST_FAULT && mpu_reset_o == 1'b0;
  endproperty
  a_osc_fault: assert property (p_osc_fault) else $error("crystal fault not caught");

  property p_count_zero;
    @(posedge clk_i) disable iff (srst_i) mpu_launch_o |-> wd_cnt == `ZERO16;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("count not fresh at launch");

endmodule : hw_watchdog_reset_control

`default_nettype wire

// ### tb/mpu_firmware_model.sv
// Firmware model of the MPU core: watchdog refresh and boot-time flag handling
`default_nettype none

module mpu_firmware_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Bench controls
  input wire logic refresh_en_i,
  input wire logic clear_en_i,
  input wire logic [11:0] refresh_gap_i,
  // Device side
  input wire logic mpu_reset_i,
  input wire logic mpu_launch_i,
  input wire logic flag_i,
  output logic refresh_wr_o,
  output logic flag_clr_o,
  output logic boot_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [11:0] gap;

  // ****************************************
  // Firmware behaviour
  // ****************************************
  // A large gap models slow firmware that lets the watchdog run out
  always_ff @(posedge clk_i) begin
    if (srst_i || mpu_reset_i) begin
      gap <= 12'h000;
      refresh_wr_o <= 1'b0;
    end else if (refresh_en_i && gap >= refresh_gap_i) begin
      gap <= 12'h000;
      refresh_wr_o <= 1'b1;
    end else begin
      gap <= gap + 12'h001;
      refresh_wr_o <= 1'b0;
    end
  end

  // Boot code reads the flag once and clears it when allowed
  always_ff @(posedge clk_i) begin
    if (srst_i || mpu_reset_i) begin
      boot_flag_o <= 1'b0;
      flag_clr_o <= 1'b0;
    end else if (mpu_launch_i) begin
      boot_flag_o <= flag_i;
      flag_clr_o <= clear_en_i & flag_i;
    end else begin
      flag_clr_o <= 1'b0;
    end
  end
endmodule : mpu_firmware_model

`default_nettype wire

// ### tb/hw_watchdog_reset_control_test.sv
// Self-checking bench for the hardware watchdog and reset control
`default_nettype none
`include "hw_watchdog_params.svh"

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module hw_watchdog_reset_control_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Stimulus and wiring
  // ****************************************
  localparam int XH = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic vbat = 1'b1;
  logic xtal = 1'b0;
  logic xtal_run = 1'b1;
  logic ext_n = 1'b1;
  logic emu_n = 1'b1;
  logic pf_below = 1'b0;
  logic pf_dis = 1'b0;
  logic wake = 1'b1;
  logic dbg_valid = 1'b0;
  logic [7:0] dbg_cmd = 8'h00;
  logic fw_en = 1'b1;
  logic clr_en = 1'b0;
  logic [11:0] gap = 12'h078;
  logic refresh_wr, flag_clr, boot_flag;
  logic rst, launch, halt, cfg_clr, flag;
  int xcnt = 0;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  wire logic [2:0] obs = {flag, rst, launch};

  always #2 clk = ~clk;

  // Crystal stands still while stopped, as a dead oscillator would
  always @(posedge clk) begin
    if (xtal_run) begin
      xcnt <= (xcnt == XH - 1) ? 0 : xcnt + 1;
      if (xcnt == XH - 1) begin
        xtal <= ~xtal;
      end
    end
  end

  hw_watchdog_reset_control #(.WD_LIMIT(8), .LAUNCH_DELAY(4), .OSC_SLOW_LIMIT(80)) i_hw_watchdog_reset_control (
    .clk_i(clk), .srst_i(srst), .vbat_srst_i(vbat), .crystal_clock_32k_i(xtal),
    .external_reset_pin_n_i(ext_n), .emulator_reset_pin_n_i(emu_n),
    .power_fault_sense_below_i(pf_below), .power_fault_sense_wd_disable_i(pf_dis), .wake_i(wake),
    .watchdog_refresh_bit_wr_i(refresh_wr), .watchdog_overflow_flag_clr_i(flag_clr),
    .debug_cmd_valid_i(dbg_valid), .debug_cmd_i(dbg_cmd), .mpu_reset_o(rst), .mpu_launch_o(launch),
    .digital_halt_o(halt), .config_ram_clear_o(cfg_clr), .watchdog_overflow_flag_o(flag));

  mpu_firmware_model i_mpu_firmware_model (
    .clk_i(clk), .srst_i(srst), .refresh_en_i(fw_en), .clear_en_i(clr_en), .refresh_gap_i(gap),
    .mpu_reset_i(rst), .mpu_launch_i(launch), .flag_i(flag), .refresh_wr_o(refresh_wr),
    .flag_clr_o(flag_clr), .boot_flag_o(boot_flag));

  // ****************************************
  // Helpers and scenarios
  // ****************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // Command and its strobe change together; the strobe stands for one edge and the command is left in place
  task automatic send_cmd(input logic [7:0] c);
    @(posedge clk) begin
      dbg_valid <= 1'b1;
      dbg_cmd <= c;
    end
    @(posedge clk) dbg_valid <= 1'b0;
  endtask : send_cmd

  // Bit 0 launch, 1 reset, 2 flag; bounded so a hang is reported
  task automatic wait_bit(input int b, input logic v, input int lim, output int cnt);
    cnt = 0;
    do begin
      cyc(1);
      cnt++;
    end while (obs[b] !== v && cnt < lim);
    `CHK(obs[b], v)
  endtask : wait_bit

  task automatic t_refresh;
    wait_bit(0, 1'b1, 600, n);
    `CHK({flag, halt, cfg_clr}, 3'b000)
    cyc(1200);
    `CHK({flag, rst}, 2'b00)
    @(posedge clk) fw_en <= 1'b0;
    @(posedge clk) wake <= 1'b0;
    cyc(800);
    `CHK(flag, 1'b0)
    @(posedge clk) wake <= 1'b1;
    repeat (5) begin
      send_cmd(8'h14);
      cyc(150);
    end
    `CHK(flag, 1'b0)
  endtask : t_refresh

  task automatic t_overflow;
    // Restart, then an unrelated command 100 cycles on must not restart again
    send_cmd(8'h14);
    cyc(100);
    send_cmd(8'h15);
    wait_bit(2, 1'b1, 400, n);
    `CHK(n inside {[175:225]}, 1'b1)
    `CHK(rst, 1'b1)
    wait_bit(1, 1'b0, 5000, n);
    `CHK(n, `RST_PULSE_CYCLES)
    wait_bit(0, 1'b1, 400, n);
    `CHK(n inside {[120:208]}, 1'b1)
    cyc(3);
    `CHK({flag, boot_flag}, 2'b11)
    @(posedge clk) srst <= 1'b1;
    cyc(2);
    `CHK(flag, 1'b1)
    @(posedge clk) srst <= 1'b0;
    @(posedge clk) fw_en <= 1'b1;
    wait_bit(0, 1'b1, 600, n);
  endtask : t_overflow

  task automatic t_pins;
    @(posedge clk) ext_n <= 1'b0;
    cyc(6);
    `CHK({rst, halt, cfg_clr, flag}, 4'b1110)
    @(posedge clk) ext_n <= 1'b1;
    wait_bit(0, 1'b1, 600, n);
    @(posedge clk) emu_n <= 1'b0;
    cyc(6);
    `CHK({rst, halt}, 2'b10)
    @(posedge clk) emu_n <= 1'b1;
    wait_bit(0, 1'b1, 600, n);
    @(posedge clk) pf_below <= 1'b1;
    cyc(6);
    `CHK({rst, halt, cfg_clr}, 3'b111)
    @(posedge clk) pf_dis <= 1'b1;
    wait_bit(0, 1'b1, 600, n);
    `CHK(halt, 1'b0)
    @(posedge clk) fw_en <= 1'b0;
    cyc(600);
    `CHK({flag, rst}, 2'b00)
    @(posedge clk) fw_en <= 1'b1;
    @(posedge clk) pf_below <= 1'b0;
    @(posedge clk) pf_dis <= 1'b0;
  endtask : t_pins

  task automatic t_xtal;
    @(posedge clk) clr_en <= 1'b1;
    @(posedge clk) xtal_run <= 1'b0;
    cyc(200);
    `CHK({flag, rst}, 2'b10)
    @(posedge clk) xtal_run <= 1'b1;
    wait_bit(1, 1'b1, 100, n);
    wait_bit(0, 1'b1, 4400, n);
    cyc(3);
    `CHK({boot_flag, flag}, 2'b10)
  endtask : t_xtal

  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    vbat <= 1'b0;
    t_refresh;
    t_overflow;
    t_pins;
    t_xtal;
    end_of_test;
  end

  initial begin
    #200000;
    num_errors++;
    $display("Error at %0t: run did not finish", $time);
    end_of_test;
  end
endmodule : hw_watchdog_reset_control_test

`default_nettype wire
